// [design/i2c_target_params.svh]
// Constants for the two-wire register target port
`ifndef I2C_TARGET_PARAMS_SVH
`define I2C_TARGET_PARAMS_SVH
`define ADDR_UPPER        6'h0C
`define SUB_INDEX_MSB     6
`define REG_COUNT         128
`define PTR_ADV_INDEX     7'h10
`define PTR_ADV_BIT       2
`define QUEUE_TAG_INDEX   7'h40
`define QUEUE_LAST_INDEX  7'h46
`define BIT_LAST          3'h7
`define CLK_PERIOD_NS     8
`define FASTPLUS_KHZ      1000
`define FAST_KHZ          400
// Half period at the top bus rate, in system clocks (62 at 125 MHz)
`define FASTPLUS_HALF_CYC ((1000000 / `FASTPLUS_KHZ) / 2 / `CLK_PERIOD_NS)
`endif

// [design/i2c_target_pkg.sv]
// Types for the two-wire register target port
package i2c_target_pkg;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_AACK  = 3'b010,
    S_RX    = 3'b011,
    S_RXACK = 3'b100,
    S_TX    = 3'b101,
    S_TXACK = 3'b110,
    S_START = 3'b111
  } tgt_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  typedef struct packed {
    logic       we;
    logic [6:0] index;
    logic [7:0] data;
  } reg_write_t;
endpackage

// [design/i2c_register_target.sv]
// Two-wire serial register target with internal register array
// Behaviour
// - Port works only while interface select pin is high.
// - Falling SDA with SCL high opens a transaction; bus busy.
// - Device responds only on exact seven-bit address match.
// - Address is fixed upper six bits plus LSB from select pin.
// - Receiver holds SDA low through acknowledge clock high phase.
// - Addressed receiver acknowledges address, subaddress and each data byte.
// - Subaddress byte follows address; low seven bits select the register.
// - Write data bytes follow subaddress; each stored and acknowledged.
// - Device sends bytes while acknowledged, releases SDA on no-acknowledge.
// - Bytes are eight bits, MSB first, unlimited count.
// - Unaddressed device leaves SDA high in acknowledge slot.
// - Rising SDA with SCL high closes transaction, back to idle.
// - Device never pulls lines low while bus is free.
// - Works at normal, fast and fast-plus clock rates.
// - Pointer advance bit set increments index per byte, else holds.
// - Queue output registers wrap from last data byte to tag.
`timescale 1ns/1ns
`include "i2c_target_params.svh"
module i2c_register_target (
  // Clock and reset
  input  wire logic                       i_mclk,
  input  wire logic                       i_srst,
  // Straps
  input  wire logic                       i_interface_select,
  input  wire logic                       i_address_lsb_select_pin,
  // Bus lines
  input  wire i2c_target_pkg::bus_lines_t i_bus,
  output logic                            o_sda,
  output logic                            o_sda_oe_n,
  output logic                            o_scl,
  output logic                            o_scl_oe_n,
  // Status
  output logic                            o_busy,
  output logic                            o_addressed,
  // Store strobe towards device logic
  output i2c_target_pkg::reg_write_t      o_write
);
  import i2c_target_pkg::*;

  // Two-stage synchronisers; first stage read only by second
  bus_lines_t sync1, sync2, prev;
  logic       sel1, sel2, lsb1, lsb2;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
      prev  <= 2'h3;
      sel1  <= 1'h0;
      sel2  <= 1'h0;
      lsb1  <= 1'h0;
      lsb2  <= 1'h0;
    end else begin
      sync1 <= i_bus;
      sync2 <= sync1;
      prev  <= sync2;
      sel1  <= i_interface_select;
      sel2  <= sel1;
      lsb1  <= i_address_lsb_select_pin;
      lsb2  <= lsb1;
    end
  end

  // Sampled at 125 MHz: 62 clocks per fast-plus half period is ample margin
  logic enabled, scl_rise, scl_fall, open_cond, close_cond;
  assign enabled    = sel2;
  assign scl_rise   = !prev.scl && sync2.scl;
  assign scl_fall   = prev.scl && !sync2.scl;
  assign open_cond  = enabled && prev.scl && sync2.scl && prev.sda && !sync2.sda;
  assign close_cond = enabled && prev.scl && sync2.scl && !prev.sda && sync2.sda;

  logic [6:0] own_addr;
  assign own_addr = {`ADDR_UPPER, lsb2};

  // Register array; index 7'h10 bit 2 steers pointer advance
  logic [7:0] regs [`REG_COUNT];

  tgt_state_t state, next_state;
  logic [2:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [6:0] ptr, next_ptr;
  logic       read_dir, next_read_dir;
  logic       have_sub, next_have_sub;
  logic       sda_low, next_sda_low;
  logic       busy, next_busy;
  logic       addressed, next_addressed;
  reg_write_t wr, next_wr;
  logic       adv;

  assign adv = regs[`PTR_ADV_INDEX][`PTR_ADV_BIT];

  function automatic logic [6:0] step_ptr(input logic [6:0] p, input logic en);
    logic [6:0] r;
    r = p;
    if (en) begin
      if (p == `QUEUE_LAST_INDEX) begin
        r = `QUEUE_TAG_INDEX;
      end else begin
        r = p + 7'h01;
      end
    end
    return r;
  endfunction

  always_comb begin
    next_state     = state;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_ptr       = ptr;
    next_read_dir  = read_dir;
    next_have_sub  = have_sub;
    next_sda_low   = sda_low;
    next_busy      = busy;
    next_addressed = addressed;
    next_wr        = '0;
    if (!enabled || close_cond) begin
      next_state     = S_IDLE;
      next_sda_low   = 1'h0;
      next_busy      = 1'h0;
      next_addressed = 1'h0;
    end else if (open_cond) begin
      // Abort whatever was in flight; nothing partial is stored
      next_state     = S_START;
      next_bitcnt    = 3'h0;
      next_sda_low   = 1'h0;
      next_busy      = 1'h1;
      next_addressed = 1'h0;
      next_have_sub  = 1'h0;
    end else begin
      unique case (state)
        S_IDLE: begin
          next_sda_low = 1'h0;
        end
        // SCL fall that completes the opening is no data bit; skip it
        S_START: begin
          if (scl_fall) begin
            next_bitcnt = 3'h0;
            next_state  = S_ADDR;
          end
        end
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sync2.sda};
          end else if (scl_fall && bitcnt == `BIT_LAST) begin
            next_bitcnt = 3'h0;
            if (state == S_ADDR) begin
              if (shreg[7:1] == own_addr) begin
                next_read_dir  = shreg[0];
                next_addressed = 1'h1;
                next_sda_low   = 1'h1;
                next_state     = S_AACK;
              end else begin
                next_state = S_IDLE;
              end
            end else begin
              next_sda_low = 1'h1;
              next_state   = S_RXACK;
              if (!have_sub) begin
                next_ptr      = shreg[`SUB_INDEX_MSB:0];
                next_have_sub = 1'h1;
              end else begin
                next_wr.we    = 1'h1;
                next_wr.index = ptr;
                next_wr.data  = shreg;
                next_ptr      = step_ptr(ptr, adv);
              end
            end
          end else if (scl_fall) begin
            next_bitcnt = bitcnt + 3'h1;
          end
        end
        S_AACK, S_RXACK: begin
          // Held low through the whole high phase; on the falling edge released, or set to the first bit of a read
          if (scl_fall) begin
            if (state == S_AACK && read_dir) begin
              next_shreg   = regs[ptr];
              next_sda_low = !regs[ptr][7];
              next_ptr     = step_ptr(ptr, adv);
              next_state   = S_TX;
            end else begin
              next_sda_low = 1'h0;
              next_state   = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bitcnt == `BIT_LAST) begin
              next_bitcnt  = 3'h0;
              next_sda_low = 1'h0;
              next_state   = S_TXACK;
            end else begin
              next_bitcnt  = bitcnt + 3'h1;
              next_shreg   = {shreg[6:0], 1'h0};
              next_sda_low = !shreg[6];
            end
          end
        end
        S_TXACK: begin
          if (scl_rise) begin
            next_read_dir = !sync2.sda;
          end else if (scl_fall) begin
            if (read_dir) begin
              next_shreg   = regs[ptr];
              next_sda_low = !regs[ptr][7];
              next_ptr     = step_ptr(ptr, adv);
              next_state   = S_TX;
            end else begin
              next_sda_low = 1'h0;
              next_state   = S_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state     <= S_IDLE;
      bitcnt    <= 3'h0;
      shreg     <= 8'h00;
      ptr       <= 7'h00;
      read_dir  <= 1'h0;
      have_sub  <= 1'h0;
      sda_low   <= 1'h0;
      busy      <= 1'h0;
      addressed <= 1'h0;
      wr        <= '0;
    end else begin
      state     <= next_state;
      bitcnt    <= next_bitcnt;
      shreg     <= next_shreg;
      ptr       <= next_ptr;
      read_dir  <= next_read_dir;
      have_sub  <= next_have_sub;
      sda_low   <= next_sda_low;
      busy      <= next_busy;
      addressed <= next_addressed;
      wr        <= next_wr;
    end
  end

  // Register array store; no reset so it maps to plain memory
  always_ff @(posedge i_mclk) begin
    if (wr.we) begin
      regs[wr.index] <= wr.data;
    end
  end

  assign o_sda       = 1'h0;
  assign o_sda_oe_n  = !sda_low;
  assign o_scl       = 1'h0;
  assign o_scl_oe_n  = 1'h1;
  assign o_busy      = busy;
  assign o_addressed = addressed;
  assign o_write     = wr;

  // Checks
  free_bus_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !busy |-> o_sda_oe_n) else $error("SDA pulled while bus free");
  sel_off_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !enabled |=> !busy && o_sda_oe_n) else $error("Port active while deselected");
  open_busy_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    open_cond |=> busy && state == S_START) else $error("Opening not seen");
  start_skip_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    state == S_START && scl_fall && enabled && !open_cond && !close_cond
    |=> state == S_ADDR && bitcnt == 3'h0) else $error("Address count misaligned");
  close_idle_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    close_cond |=> !busy && state == S_IDLE) else $error("Closing not seen");
  addr_match_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    state == S_ADDR && next_state == S_AACK |-> shreg[7:1] == own_addr)
    else $error("Acked wrong address");
  no_match_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    state == S_ADDR && scl_fall && bitcnt == `BIT_LAST && shreg[7:1] != own_addr
    && enabled && !open_cond && !close_cond |=> o_sda_oe_n && state == S_IDLE)
    else $error("Responded to foreign address");
  rx_ack_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    state == S_RX && scl_fall && bitcnt == `BIT_LAST && enabled && !open_cond
    && !close_cond |=> state == S_RXACK && !o_sda_oe_n) else $error("Byte not acknowledged");
  ack_hold_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state == S_AACK || state == S_RXACK) && !scl_fall && enabled && !open_cond
    && !close_cond |=> !o_sda_oe_n) else $error("Ack released early");
  sub_first_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_write.we |-> have_sub && state == S_RXACK) else $error("Stored before subaddress");
  abort_nowrite_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    open_cond |=> !o_write.we) else $error("Partial byte stored");
  wrap_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    wr.we && $past(ptr) == `QUEUE_LAST_INDEX && adv |-> ptr == `QUEUE_TAG_INDEX)
    else $error("Queue pointer did not wrap");
  nak_release_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    state == S_TXACK && !read_dir && scl_fall && enabled && !open_cond && !close_cond
    |=> state == S_IDLE ##1 o_sda_oe_n) else $error("Drove after no-ack");
endmodule

// [bench/i2c_controller_model.sv]
// Behavioural two-wire bus controller that drives the target's far side
`timescale 1ns/1ns
module i2c_controller_model (
  // Clock used only to pace the bus
  input  wire logic i_mclk,
  // Resolved data line
  input  wire logic i_sda,
  // Line levels, high means released
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Quarter of a 160 ns bus clock
  task automatic q();
    repeat (5) @(posedge i_mclk);
    #1;
  endtask
  // Also serves as repeated opening, since SCL is low between bytes
  task automatic open_bus();
    o_sda = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda = 1'b0;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic xbit(input logic b, output logic r);
    o_sda = b;
    q();
    o_scl = 1'b1;
    q();
    r = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = (r === 1'b0);
  endtask
  // Last byte gets no acknowledge
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(last, r);
  endtask
  task automatic close_bus();
    o_sda = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda = 1'b1;
    q();
    q();
  endtask
endmodule

// [bench/sensor_i2c_register_target_test.sv]
// Self-checking bench for the two-wire register target
`timescale 1ns/1ns
`include "i2c_target_params.svh"
module sensor_i2c_register_target_test;
  import i2c_target_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_srst = 1'b1;
  logic        sel = 1'b1;
  logic        lsb = 1'b1;
  logic        ctl_scl, ctl_sda, oe_n, sda_v, scl_v, scl_oe_n, busy, addressed;
  bus_lines_t  bus;
  reg_write_t  wr;
  logic [14:0] wr_q[$];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  always #4 i_mclk = ~i_mclk;
  // Open-drain lines with pull-ups
  assign bus = {ctl_scl & (scl_oe_n | scl_v), ctl_sda & (oe_n | sda_v)};
  i2c_register_target u_dut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_interface_select(sel),
    .i_address_lsb_select_pin(lsb), .i_bus(bus), .o_sda(sda_v), .o_sda_oe_n(oe_n),
    .o_scl(scl_v), .o_scl_oe_n(scl_oe_n), .o_busy(busy), .o_addressed(addressed),
    .o_write(wr));
  i2c_controller_model u_ctl (.i_mclk(i_mclk), .i_sda(bus.sda), .o_scl(ctl_scl),
    .o_sda(ctl_sda));
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (wr.we === 1'b1) wr_q.push_back({wr.index, wr.data});
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_wr(input logic [6:0] idx, input logic [7:0] d);
    check(wr_q.size() > 0 ? {1'b0, wr_q.pop_front()} : 16'hFFFF, {1'b0, idx, d});
  endtask
  task automatic hdr(input logic [7:0] sub);
    logic a;
    u_ctl.open_bus();
    u_ctl.send_byte({`ADDR_UPPER, lsb, 1'b0}, a);
    check(a, 1'b1);
    check(addressed, 1'b1);
    u_ctl.send_byte(sub, a);
    check(a, 1'b1);
  endtask
  task automatic wb(input logic [7:0] d);
    logic a;
    u_ctl.send_byte(d, a);
    check(a, 1'b1);
  endtask
  task automatic t_write();
    hdr(8'h10);
    wb(8'h04);
    check_wr(7'h10, 8'h04);
    u_ctl.close_bus();
    hdr(8'h20);
    check(busy, 1'b1);
    wb(8'hA5);
    wb(8'h3C);
    u_ctl.close_bus();
    check_wr(7'h20, 8'hA5);
    check_wr(7'h21, 8'h3C);
    check({busy, addressed, oe_n}, 3'b001);
  endtask
  task automatic t_read();
    logic       a;
    logic [7:0] d;
    hdr(8'h46);
    wb(8'h5A);
    wb(8'hC3);
    check_wr(7'h46, 8'h5A);
    check_wr(7'h40, 8'hC3);
    u_ctl.close_bus();
    hdr(8'h46);
    u_ctl.open_bus();
    u_ctl.send_byte({`ADDR_UPPER, lsb, 1'b1}, a);
    check(a, 1'b1);
    u_ctl.recv_byte(1'b0, d);
    check(d, 8'h5A);
    u_ctl.recv_byte(1'b1, d);
    check(d, 8'hC3);
    check(oe_n, 1'b1);
    u_ctl.close_bus();
  endtask
  task automatic t_hold();
    hdr(8'h10);
    wb(8'h00);
    u_ctl.close_bus();
    check_wr(7'h10, 8'h00);
    hdr(8'h30);
    wb(8'h01);
    wb(8'h02);
    u_ctl.close_bus();
    check_wr(7'h30, 8'h01);
    check_wr(7'h30, 8'h02);
  endtask
  task automatic t_addr();
    logic a;
    for (int p = 0; p < 2; p++) begin
      lsb = p[0];
      repeat (4) @(posedge i_mclk);
      #1;
      u_ctl.open_bus();
      u_ctl.send_byte({`ADDR_UPPER, ~lsb, 1'b0}, a);
      check(a, 1'b0);
      check(addressed, 1'b0);
      u_ctl.close_bus();
      hdr(8'h10);
      u_ctl.close_bus();
    end
  endtask
  task automatic t_abort();
    logic a;
    hdr(8'h50);
    for (int i = 0; i < 4; i++) begin
      u_ctl.xbit(1'b1, a);
    end
    u_ctl.open_bus();
    check(wr_q.size(), 0);
    u_ctl.send_byte({`ADDR_UPPER, lsb, 1'b0}, a);
    check(a, 1'b1);
    u_ctl.close_bus();
    check(wr_q.size(), 0);
  endtask
  task automatic t_desel();
    logic a;
    sel = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    u_ctl.open_bus();
    u_ctl.send_byte({`ADDR_UPPER, lsb, 1'b0}, a);
    check({a, oe_n}, 2'b01);
    u_ctl.close_bus();
    sel = 1'b1;
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    #1;
    i_srst = 1'b0;
    repeat (4) @(posedge i_mclk);
    #1;
    check({oe_n, scl_oe_n, busy}, 3'b110);
    t_write();
    t_read();
    t_hold();
    t_addr();
    t_abort();
    t_desel();
    complete_run();
  end
endmodule
